// >>> design/arb_params.svh
`ifndef ARB_PARAMS_SVH
`define ARB_PARAMS_SVH

// ==========================================================
// Register offsets (7-bit SPI address)
`define ARB_LAST_LONG_ADDR 7'h1b
`define ARB_LAST_SHORT_ADDR 7'h0d
`define ARB_TAMPER_CTRL_ADDR 7'h20
`define ARB_CURRENT1_CTRL_ADDR 7'h21

// ==========================================================
// Byte slots inside one channel group of four
`define ARB_SLOT_TAG 2'd0
`define ARB_SLOT_HIGH 2'd1
`define ARB_SLOT_MID 2'd2
`define ARB_SLOT_LOW 2'd3

// ==========================================================
// Control register fields and reset value
`define ARB_ON_BIT 0
`define ARB_TEMP_BIT 1
`define ARB_GAIN_LSB 4
`define ARB_GAIN_MSB 5
`define ARB_CTRL_RESET 8'h00

// ==========================================================
// Channel tags; tamper tag sits in bits 3:0 of its register
`define ARB_TAMPER_TAG 4'h1
`define ARB_CURRENT1_TAG 8'h02
`define ARB_VOLTAGE1_TAG 8'h03
`define ARB_CURRENT2_TAG 8'h04
`define ARB_VOLTAGE2_TAG 8'h05
`define ARB_CURRENT3_TAG 8'h06
`define ARB_VOLTAGE3_TAG 8'h07
`define ARB_NUM_CHANNELS 7

// ==========================================================
// Converter start-up time before the on bit reads back as one
`define ARB_ON_TIME_US 768
`define ARB_CLK_MHZ 125
`define ARB_ON_CYCLES (`ARB_ON_TIME_US * `ARB_CLK_MHZ)

`endif

// >>> design/arb_pkg.sv
package arb_pkg;

  // ==========================================================
  // Serial frame phases
  typedef enum logic [2:0] {
    ARB_IDLE = 3'b001,
    ARB_ADDR = 3'b010,
    ARB_DATA = 3'b100
  } arb_state_t;

  // ==========================================================
  // Converter input stage gain
  typedef enum logic [1:0] {
    gain_times_one = 2'h0,
    gain_times_two = 2'h1,
    gain_times_four = 2'h2,
    gain_times_eight = 2'h3
  } arb_gain_t;

endpackage

// >>> design/arb_sync2.sv
`timescale 1ns/1ns
// Two-stage synchroniser for a pin input
module arb_sync2 (
  input wire logic clk,
  input wire logic rstn,
  input wire logic d,
  output logic q
);
  logic meta;

  // ==========================================================
  // Register both stages; only the second stage is read outside
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // arb_sync2

// >>> design/arb_on_delay.sv
`timescale 1ns/1ns
`include "arb_params.svh"
// Holds off the readback of an enable until start-up time passes
module arb_on_delay #(
  parameter int COUNT = `ARB_ON_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic on_in,
  output logic on_seen
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_on_seen;

  // ==========================================================
  // Count while enabled; clearing the enable drops the flag at once
  always_comb begin
    next_cnt = cnt;
    next_on_seen = on_seen;
    if (!on_in) begin
      next_cnt = '0;
      next_on_seen = 1'b0;
    end else if (cnt == CW'(COUNT - 1)) begin
      next_on_seen = 1'b1; // R6
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= '0;
      on_seen <= 1'b0;
    end else begin
      cnt <= next_cnt;
      on_seen <= next_on_seen;
    end
  end

  // ==========================================================
  // Checks
  AST_ON_NOT_EARLY: assert property (@(posedge clk) disable iff (!rstn) // R6
    $rose(on_in) |=> !on_seen [*8])
    else $error("enable read back as one too early");
  AST_ON_DROPS: assert property (@(posedge clk) disable iff (!rstn) // R6
    $fell(on_in) |=> !on_seen)
    else $error("readback stayed one after disable");
  COV_ON_SEEN: cover property (@(posedge clk) disable iff (!rstn) $rose(on_seen));
endmodule // arb_on_delay

// >>> design/arb_result_bank.sv
`timescale 1ns/1ns
`include "arb_params.svh"
// Notes on behaviour
// R1: Each result shows as high, mid, low bytes
// R2: Tag registers return fixed channel identifiers
// R3: Short mode hides tags and low bytes
// R4: High and mid byte addresses follow mode
// R5: Upper channels exist only in larger variants
// R6: Enable reads back one after 768 us
// R7: Tamper temp-select bit picks sensor input
// R8: Host waits for settled flag before writing
// R9: Two-bit gain field sets x1 to x8
// R10: On bit 0, temp bit 1, gain 5:4
// R11: Short mode packs high/mid bytes from zero
// R12: Tamper tag carries data-settled flag
module arb_result_bank
  import arb_pkg::*;
#(
  parameter int NUM_CHANNELS = `ARB_NUM_CHANNELS,
  parameter int ON_CYCLES = `ARB_ON_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ncs,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [167:0] result_in,
  input wire logic result_load,
  input wire logic short_result_mode,
  input wire logic data_settled,
  output logic tamper_converter_on,
  output logic temp_sensor_select,
  output arb_gain_t tamper_gain,
  output logic current1_converter_on,
  output arb_gain_t current1_gain
);

  // ==========================================================
  // Pin synchronisers
  logic cs_s;
  logic sclk_s;
  logic mosi_s;
  logic sclk_d;
  logic sclk_rise;
  logic sclk_fall;
  arb_sync2 u_sync_ncs (.clk(clk), .rstn(rstn), .d(~ncs), .q(cs_s)); // Inverted: reset value reads deselected
  arb_sync2 u_sync_sclk (.clk(clk), .rstn(rstn), .d(sclk), .q(sclk_s));
  arb_sync2 u_sync_mosi (.clk(clk), .rstn(rstn), .d(mosi), .q(mosi_s));
  // Edge finder works on the synchronised clock only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  // ==========================================================
  // Conversion results
  logic [23:0] res [`ARB_NUM_CHANNELS];
  logic [23:0] next_res [`ARB_NUM_CHANNELS];

  // Whole set loads together so a burst sees one frame
  always_comb begin
    for (int i = 0; i < `ARB_NUM_CHANNELS; i++) begin
      next_res[i] = res[i];
      if (result_load) begin
        next_res[i] = result_in[i*24 +: 24];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < `ARB_NUM_CHANNELS; i++) begin
        res[i] <= 24'h000000;
      end
    end else begin
      for (int i = 0; i < `ARB_NUM_CHANNELS; i++) begin
        res[i] <= next_res[i];
      end
    end
  end

  // ==========================================================
  // Converter start-up timers
  logic tamper_on_seen;
  logic current1_on_seen;
  arb_on_delay #(.COUNT(ON_CYCLES)) u_tamper_on (
    .clk(clk),
    .rstn(rstn),
    .on_in(tamper_converter_on),
    .on_seen(tamper_on_seen)
  );
  arb_on_delay #(.COUNT(ON_CYCLES)) u_current1_on (
    .clk(clk),
    .rstn(rstn),
    .on_in(current1_converter_on),
    .on_seen(current1_on_seen)
  );
  // ==========================================================
  // Read decode
  logic [6:0] addr;
  logic [7:0] read_byte;
  logic [2:0] rd_ch;
  logic [1:0] rd_slot;
  logic rd_hit;
  // Tag of a non-tamper channel
  function automatic logic [7:0] chan_tag(input logic [2:0] ch);
    logic [7:0] t;
    t = 8'h00;
    unique case (ch)
      3'd1: t = `ARB_CURRENT1_TAG;
      3'd2: t = `ARB_VOLTAGE1_TAG;
      3'd3: t = `ARB_CURRENT2_TAG;
      3'd4: t = `ARB_VOLTAGE2_TAG;
      3'd5: t = `ARB_CURRENT3_TAG;
      3'd6: t = `ARB_VOLTAGE3_TAG;
      default: t = 8'h00;
    endcase
    return t;
  endfunction

  // Address map shifts with the short-result mode
  always_comb begin
    read_byte = 8'h00;
    rd_ch = 3'd0;
    rd_slot = `ARB_SLOT_TAG;
    rd_hit = 1'b0;
    if (short_result_mode) begin
      // Tags and low bytes have no address here
      if (addr <= `ARB_LAST_SHORT_ADDR) begin // R3 R11
        rd_ch = addr[3:1];
        rd_slot = addr[0] ? `ARB_SLOT_MID : `ARB_SLOT_HIGH; // R4
        rd_hit = 1'b1;
      end
    end else if (addr <= `ARB_LAST_LONG_ADDR) begin
      rd_ch = addr[4:2];
      rd_slot = addr[1:0]; // R4
      rd_hit = 1'b1;
    end
    // Channels beyond the variant read as zero
    if (rd_hit && int'(rd_ch) < NUM_CHANNELS) begin // R5
      unique case (rd_slot)
        `ARB_SLOT_TAG: begin
          if (rd_ch == 3'd0) begin
            read_byte = {2'b00, data_settled, temp_sensor_select, `ARB_TAMPER_TAG}; // R12
          end else begin
            read_byte = chan_tag(rd_ch); // R2
          end
        end
        `ARB_SLOT_HIGH: read_byte = res[rd_ch][23:16]; // R1
        `ARB_SLOT_MID: read_byte = res[rd_ch][15:8]; // R1
        `ARB_SLOT_LOW: read_byte = res[rd_ch][7:0]; // R1
      endcase
    end else if (addr == `ARB_TAMPER_CTRL_ADDR) begin
      read_byte = {2'b00, tamper_gain, 2'b00, temp_sensor_select, tamper_on_seen}; // R10 R6
    end else if (addr == `ARB_CURRENT1_CTRL_ADDR) begin
      read_byte = {2'b00, current1_gain, 3'b000, current1_on_seen}; // R10 R6
    end
  end

  // ==========================================================
  // Serial frame engine
  arb_state_t state;
  arb_state_t next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic [6:0] next_addr;
  logic rd_op;
  logic next_rd_op;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic next_miso;
  logic next_miso_oe;
  logic wr_en;
  logic [7:0] wr_data;

  // Sample on falling edges, shift out on rising edges
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_rx = rx;
    next_addr = addr;
    next_rd_op = rd_op;
    next_tx = tx;
    next_miso = miso;
    next_miso_oe = 1'b0;
    wr_en = 1'b0;
    wr_data = {rx[6:0], mosi_s};
    if (!cs_s) begin
      // Partial byte is dropped: nothing written, nothing sent
      next_state = ARB_IDLE;
      next_bit_cnt = 3'd0;
      next_miso = 1'b0;
    end else begin
      unique case (state)
        ARB_IDLE: begin
          next_state = ARB_ADDR;
          next_bit_cnt = 3'd0;
        end
        ARB_ADDR: begin
          if (sclk_fall) begin
            next_rx = wr_data;
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              next_rd_op = wr_data[7];
              next_addr = wr_data[6:0];
              next_state = ARB_DATA;
            end
          end
        end
        ARB_DATA: begin
          next_miso_oe = rd_op;
          if (sclk_fall) begin
            next_rx = wr_data;
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              wr_en = ~rd_op;
              next_addr = addr + 7'd1;
            end
          end else if (sclk_rise && rd_op) begin
            if (bit_cnt == 3'd0) begin
              next_miso = read_byte[7];
              next_tx = {read_byte[6:0], 1'b0};
            end else begin
              next_miso = tx[7];
              next_tx = {tx[6:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ARB_IDLE;
      bit_cnt <= 3'd0;
      rx <= 8'h00;
      addr <= 7'h00;
      rd_op <= 1'b0;
      tx <= 8'h00;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      rx <= next_rx;
      addr <= next_addr;
      rd_op <= next_rd_op;
      tx <= next_tx;
      miso <= next_miso;
      miso_oe <= next_miso_oe;
    end
  end

  // ==========================================================
  // Control registers
  logic next_tamper_on;
  logic next_temp_sel;
  arb_gain_t next_tamper_gain;
  logic next_current1_on;
  arb_gain_t next_current1_gain;
  localparam logic [7:0] CTRL_RST = `ARB_CTRL_RESET;
  // Tamper register is not guarded here; the host waits for settle
  always_comb begin
    next_tamper_on = tamper_converter_on;
    next_temp_sel = temp_sensor_select;
    next_tamper_gain = tamper_gain;
    next_current1_on = current1_converter_on;
    next_current1_gain = current1_gain;
    if (wr_en && addr == `ARB_TAMPER_CTRL_ADDR) begin // R8
      next_tamper_on = wr_data[`ARB_ON_BIT]; // R6 R10
      next_temp_sel = wr_data[`ARB_TEMP_BIT]; // R7
      next_tamper_gain = arb_gain_t'(wr_data[`ARB_GAIN_MSB:`ARB_GAIN_LSB]); // R9
    end
    if (wr_en && addr == `ARB_CURRENT1_CTRL_ADDR) begin
      next_current1_on = wr_data[`ARB_ON_BIT]; // R6 R10
      next_current1_gain = arb_gain_t'(wr_data[`ARB_GAIN_MSB:`ARB_GAIN_LSB]); // R9
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tamper_converter_on <= CTRL_RST[`ARB_ON_BIT];
      temp_sensor_select <= CTRL_RST[`ARB_TEMP_BIT];
      tamper_gain <= arb_gain_t'(CTRL_RST[`ARB_GAIN_MSB:`ARB_GAIN_LSB]);
      current1_converter_on <= CTRL_RST[`ARB_ON_BIT];
      current1_gain <= arb_gain_t'(CTRL_RST[`ARB_GAIN_MSB:`ARB_GAIN_LSB]);
    end else begin
      tamper_converter_on <= next_tamper_on;
      temp_sensor_select <= next_temp_sel;
      tamper_gain <= next_tamper_gain;
      current1_converter_on <= next_current1_on;
      current1_gain <= next_current1_gain;
    end
  end

  // ==========================================================
  // Checks
  AST_LONG_HIGH: assert property (@(posedge clk) disable iff (!rstn) // R1
    !short_result_mode && addr == 7'h05 |-> read_byte == res[1][23:16])
    else $error("current1 high byte misread");
  AST_TAG_V1: assert property (@(posedge clk) disable iff (!rstn) // R2
    !short_result_mode && addr == 7'h08 |-> read_byte == 8'h03)
    else $error("voltage1 tag wrong");
  AST_SHORT_HIDE: assert property (@(posedge clk) disable iff (!rstn) // R3
    short_result_mode && (addr == 7'h0f || addr == 7'h18) |-> read_byte == 8'h00)
    else $error("hidden byte readable in short mode");
  AST_SHORT_MID: assert property (@(posedge clk) disable iff (!rstn) // R4
    short_result_mode && addr == 7'h03 |-> read_byte == res[1][15:8])
    else $error("short mode mid byte misplaced");
  AST_SHORT_LAST: assert property (@(posedge clk) disable iff (!rstn) // R11
    short_result_mode && addr == 7'h0c |-> read_byte == res[6][23:16])
    else $error("short mode packing wrong");
  AST_TEMP_WRITE: assert property (@(posedge clk) disable iff (!rstn) // R7
    wr_en && addr == `ARB_TAMPER_CTRL_ADDR |=> temp_sensor_select == $past(wr_data[1]))
    else $error("temp select not written");
  AST_GAIN_WRITE: assert property (@(posedge clk) disable iff (!rstn) // R9
    wr_en && addr == `ARB_CURRENT1_CTRL_ADDR |=> current1_gain == $past(wr_data[5:4]))
    else $error("gain not written");
  AST_CTRL_ZERO: assert property (@(posedge clk) disable iff (!rstn) // R10
    addr == `ARB_CURRENT1_CTRL_ADDR |-> read_byte[7:6] == 2'b00 && read_byte[3:1] == 3'b000)
    else $error("unused control bits not zero");
  AST_SETTLED: assert property (@(posedge clk) disable iff (!rstn) // R12
    !short_result_mode && addr == 7'h00 |-> read_byte[5] == data_settled && read_byte[3:0] == 4'h1)
    else $error("tamper tag settle flag wrong");
  COV_READ_BYTE: cover property (@(posedge clk) disable iff (!rstn)
    state == ARB_DATA && rd_op && sclk_fall && bit_cnt == 3'd7);
  COV_WRITE_CTRL: cover property (@(posedge clk) disable iff (!rstn) wr_en);
  COV_SHORT_READ: cover property (@(posedge clk) disable iff (!rstn)
    short_result_mode && miso_oe && sclk_rise);
endmodule // arb_result_bank

// >>> dv/arb_spi_host.sv
`timescale 1ns/1ns
// ==========
// SPI host, mode 1: clock idles low, data out on rise, in on fall
module arb_spi_host #(
  parameter int HALF = 10
) (
  input wire logic clk,
  output logic ncs,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  // Idle bus at time zero
  initial begin
    ncs = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // Open a frame; clock stands still until the first bit
  task automatic start_frame();
    @(negedge clk);
    ncs = 1'b0;
    repeat (HALF) @(negedge clk);
  endtask

  // Close a frame; mosi flips so a stale bit never looks valid
  task automatic end_frame();
    repeat (HALF) @(negedge clk);
    ncs = 1'b1;
    mosi = ~mosi;
    repeat (HALF) @(negedge clk);
  endtask

  // Shift nbits MSB first; miso taken at each fall
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      @(negedge clk);
      sclk = 1'b1;
      mosi = tx[i];
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
      rx[i] = miso;
      repeat (HALF - 1) @(negedge clk);
    end
  endtask
endmodule // arb_spi_host

// >>> dv/arb_result_bank_tb.sv
`timescale 1ns/1ns
module arb_result_bank_tb
  import arb_pkg::*;
;
  // Start-up delay kept short, yet longer than one readback frame
  localparam int ON_CYC = 1000;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rstn, ncs, sclk, mosi, miso, miso_oe;
  logic [167:0] result_in;
  logic result_load, short_result_mode, data_settled, exp_temp;
  logic tamper_converter_on, temp_sensor_select, current1_converter_on;
  arb_gain_t tamper_gain, current1_gain;
  logic [23:0] res_val [7];
  logic [7:0] rd [32];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  arb_result_bank #(.NUM_CHANNELS(7), .ON_CYCLES(ON_CYC)) dut (.clk(clk), .rstn(rstn), .ncs(ncs),
    .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .result_in(result_in),
    .result_load(result_load), .short_result_mode(short_result_mode), .data_settled(data_settled),
    .tamper_converter_on(tamper_converter_on), .temp_sensor_select(temp_sensor_select),
    .tamper_gain(tamper_gain), .current1_converter_on(current1_converter_on),
    .current1_gain(current1_gain));

  // Data line pulled up whenever the device lets go of it
  arb_spi_host host (.clk(clk), .ncs(ncs), .sclk(sclk), .mosi(mosi), .miso(miso_oe ? miso : 1'b1));

  // ==========
  // Verdict and hang guard
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      $display("mismatch at %0t: run timed out", $time);
      report_and_stop();
    end
  end

  // ==========
  // Compare, access and model helpers
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [6:0] addr, input logic [7:0] data, input int nbits = 8);
    logic [7:0] rx;
    host.start_frame();
    host.shift({1'b0, addr}, 8, rx);
    host.shift(data, nbits, rx);
    host.end_frame();
  endtask

  // Burst read; the pointer steps after every byte
  task automatic reg_read(input logic [6:0] addr, input int n);
    logic [7:0] rx;
    host.start_frame();
    host.shift({1'b1, addr}, 8, rx);
    for (int k = 0; k < n; k++) begin
      host.shift(8'h00, 8, rx);
      rd[k] = rx;
    end
    cmp8({7'h00, miso_oe}, 8'h01, "miso enable in read");
    host.end_frame();
  endtask

  // Host holds off tamper writes until the settle flag is seen or 8 polls have passed
  task automatic tamper_write(input logic [7:0] data);
    int tries;
    tries = 0;
    do begin
      reg_read(7'h00, 1);
      tries++;
    end while (rd[0][5] !== 1'b1 && tries < 8);
    cmp8({7'h00, rd[0][5]}, 8'h01, "settle flag before write");
    reg_write(7'h20, data);
  endtask

  task automatic load_results();
    @(negedge clk);
    for (int i = 0; i < 7; i++) result_in[i*24 +: 24] = res_val[i];
    result_load = 1'b1;
    @(negedge clk);
    result_load = 1'b0;
  endtask

  function automatic logic [7:0] exp_long(input int a);
    int c;
    c = a / 4;
    case (a % 4)
      0: exp_long = (c == 0) ? {2'b00, data_settled, exp_temp, 4'h1} : 8'(c + 1);
      1: exp_long = res_val[c][23:16];
      2: exp_long = res_val[c][15:8];
      default: exp_long = res_val[c][7:0];
    endcase
  endfunction

  function automatic logic [7:0] exp_short(input int a);
    if (a >= 14) return 8'h00;
    return (a % 2) ? res_val[a/2][15:8] : res_val[a/2][23:16];
  endfunction

  // ==========
  // Main sequence
  initial begin
    rstn = 1'b0;
    result_in = '0;
    result_load = 1'b0;
    short_result_mode = 1'b0;
    data_settled = 1'b1;
    exp_temp = 1'b0;
    for (int i = 0; i < 7; i++) res_val[i] = {4'ha, 4'(i), 4'h5, 4'(i + 8), 4'hc, 4'(15 - i)};
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    reg_read(7'h20, 2);
    cmp8(rd[0], 8'h00, "tamper control reset");
    cmp8(rd[1], 8'h00, "current1 control reset");
    cmp8({7'h00, miso_oe}, 8'h00, "miso enable idle");
    // Full long map: tags, then three result bytes per channel
    load_results();
    reg_read(7'h00, 28);
    for (int a = 0; a < 28; a++) cmp8(rd[a], exp_long(a), "long map byte");
    // Short map packs high and mid bytes; tags and low bytes vanish
    short_result_mode = 1'b1;
    reg_read(7'h00, 16);
    for (int a = 0; a < 16; a++) cmp8(rd[a], exp_short(a), "short map byte");
    reg_read(7'h1b, 1);
    cmp8(rd[0], 8'h00, "low byte hidden in short mode");
    short_result_mode = 1'b0;
    // Gain codes on current1 with the converter off
    for (int g = 0; g < 4; g++) begin
      reg_write(7'h21, {2'b00, 2'(g), 4'h0});
      cmp8({6'h00, current1_gain}, 8'(g), "current1 gain out");
      reg_read(7'h21, 1);
      cmp8(rd[0], {2'b00, 2'(g), 4'h0}, "current1 gain readback");
    end
    // All ones: reserved bits read zero, on bit held back
    reg_write(7'h21, 8'hff);
    cmp8({7'h00, current1_converter_on}, 8'h01, "current1 on out");
    reg_read(7'h21, 1);
    cmp8(rd[0], 8'h30, "on bit hidden early");
    repeat (ON_CYC) @(negedge clk);
    reg_read(7'h21, 1);
    cmp8(rd[0], 8'h31, "on bit after start-up");
    // Cut data byte and write to a read-only place are both dropped
    reg_write(7'h21, 8'h00, 5);
    reg_write(7'h05, 8'h5a);
    reg_read(7'h21, 1);
    cmp8(rd[0], 8'h31, "cut byte not written");
    reg_read(7'h05, 1);
    cmp8(rd[0], res_val[1][23:16], "read-only byte unchanged");
    // Tamper channel: wait for the settle flag, select the sensor
    data_settled = 1'b0;
    fork
      begin
        repeat (300) @(negedge clk);
        data_settled = 1'b1;
      end
    join_none
    tamper_write(8'hff);
    exp_temp = 1'b1;
    cmp8({7'h00, temp_sensor_select}, 8'h01, "sensor selected");
    cmp8({6'h00, tamper_gain}, 8'h03, "tamper gain out");
    cmp8({7'h00, tamper_converter_on}, 8'h01, "tamper on out");
    reg_read(7'h20, 1);
    cmp8(rd[0], 8'h32, "tamper readback early");
    repeat (ON_CYC) @(negedge clk);
    reg_read(7'h00, 1);
    cmp8(rd[0], exp_long(0), "tamper tag shows sensor");
    reg_read(7'h20, 1);
    cmp8(rd[0], 8'h33, "tamper readback late");
    tamper_write(8'h00);
    exp_temp = 1'b0;
    cmp8({7'h00, temp_sensor_select}, 8'h00, "external input selected");
    reg_read(7'h20, 1);
    cmp8(rd[0], 8'h00, "on clears at once");
    report_and_stop();
  end
endmodule // arb_result_bank_tb
